// ==== rtl/pmsc_pkg.sv ====
// Package for the port MAC statistics counter bank: map, resets, event carriers.
package pmsc_pkg;

	// ------------------------------------------------------------
	// Register indexes; the byte address is four times the index.
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_RX_FRAME_TOTAL = 8'ha0;
	localparam logic [7:0] IDX_RX_BROADCAST_FRAMES = 8'ha1;
	localparam logic [7:0] IDX_RX_MULTICAST_FRAMES = 8'ha2;
	localparam logic [7:0] IDX_RX_UNICAST_FRAMES = 8'ha3;
	localparam logic [7:0] IDX_RX_FCS_ERROR_FRAMES = 8'ha4;
	localparam logic [7:0] IDX_RX_ALIGNMENT_ERRORS = 8'ha5;
	localparam logic [7:0] IDX_RX_LENGTH_ERRORS = 8'ha6;
	localparam logic [7:0] IDX_RX_PHY_ERROR_FRAMES = 8'ha7;
	localparam logic [7:0] IDX_TX_FRAME_TOTAL = 8'ha8;
	localparam logic [7:0] IDX_TX_BROADCAST_FRAMES = 8'ha9;
	localparam logic [7:0] IDX_TX_MULTICAST_FRAMES = 8'haa;
	localparam logic [7:0] IDX_TX_UNICAST_FRAMES = 8'hab;
	localparam logic [7:0] IDX_RX_DROPS_FIFO_FULL = 8'hac;
	localparam logic [7:0] IDX_RX_DROPS_FILTERED = 8'had;
	localparam logic [7:0] IDX_RX_GAP_ERROR_FRAMES = 8'hae;
	localparam logic [7:0] IDX_RX_MIN_GAP_THRESHOLD = 8'hb5;
	localparam logic [7:0] IDX_RX_MAX_LENGTH_LIMIT = 8'hb6;
	localparam logic [7:0] IDX_RX_MIN_LENGTH_LIMIT = 8'hb7;

	// ------------------------------------------------------------
	// Counter slots, widths and reset values.
	// ------------------------------------------------------------
	localparam int CNT_NUM = 15;
	localparam int CNT_W = 32;
	localparam int SLOT_RX_TOTAL = 0;
	localparam int SLOT_RX_BCAST = 1;
	localparam int SLOT_RX_MCAST = 2;
	localparam int SLOT_RX_UCAST = 3;
	localparam int SLOT_RX_FCS = 4;
	localparam int SLOT_RX_ALIGN = 5;
	localparam int SLOT_RX_LENGTH = 6;
	localparam int SLOT_RX_PHY = 7;
	localparam int SLOT_TX_TOTAL = 8;
	localparam int SLOT_TX_BCAST = 9;
	localparam int SLOT_TX_MCAST = 10;
	localparam int SLOT_TX_UCAST = 11;
	localparam int SLOT_DROP_FULL = 12;
	localparam int SLOT_DROP_FILT = 13;
	localparam int SLOT_RX_GAP = 14;
	localparam logic [31:0] CNT_RESET = 32'h0;
	localparam logic [5:0] GAP_THRESHOLD_RESET = 6'ha;
	localparam logic [15:0] MAX_LENGTH_RESET = 16'h618;
	localparam logic [15:0] MIN_LENGTH_RESET = 16'h40;
	localparam int GAP_UNIT_SHIFT = 3;

	// ------------------------------------------------------------
	// Destination classes and per-frame event carriers.
	// ------------------------------------------------------------
	typedef enum logic [1:0] {CLS_UNICAST, CLS_MULTICAST, CLS_BROADCAST} pmsc_class_type;

	typedef struct packed {
		logic valid;
		logic [47:0] dest_addr;
		logic [15:0] length;
		logic [15:0] gap_bits;
		logic fcs_err;
		logic align_err;
		logic phy_err;
		logic filter_reject;
		logic to_host;
		logic to_port;
		logic host_fifo_full;
		logic port_fifo_full;
	} pmsc_rx_event_type;

	typedef struct packed {
		logic valid;
		logic [47:0] dest_addr;
	} pmsc_tx_event_type;

endpackage : pmsc_pkg

// ==== rtl/pmsc_counters.sv ====
// Statistics counter bank of the first port MAC with its Avalon-MM slave.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
// Functional notes
// - Total receive counter advances for every received frame, good or bad.
// - Receive broadcast counter advances for good and bad broadcast frames.
// - Receive multicast counter advances for good and bad multicast frames.
// - Receive unicast counter advances once per unicast frame received.
// - FCS error counter advances once per frame failing its check sequence.
// - Alignment error counter advances once per frame flagged misaligned.
// - Length error counter advances once per frame too long or too short.
// - PHY error counter advances once per frame with a receive error.
// - Transmit total counter advances once per frame sent.
// - Transmit broadcast counter advances once per broadcast frame sent.
// - Transmit multicast counter advances once per multicast frame sent.
// - Transmit unicast counter advances once per unicast frame sent.
// - FIFO-full drop counter advances when a frame cannot be queued.
// - Flooded frame counts as full drop only when both FIFOs are full.
// - Filter drop counter advances once per frame rejected by filtering.
// - Gap error counter advances once per frame with a gap violation.
// - All counters are 32-bit, read-only and zero after reset.
// - Gap not above threshold times eight bits drops frame, raises event.
// - Length limits are programmable, default 0x618 maximum and 0x40 minimum.

module pmsc_counters
(
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// Avalon-MM slave.
	input wire logic [9:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Frame events from the MAC, one-cycle pulses on mclk_in.
	input wire pmsc_pkg::pmsc_rx_event_type rx_event_in,
	input wire pmsc_pkg::pmsc_tx_event_type tx_event_in,
	// Gap error results back to the receive path.
	output logic rx_gap_error_event_out,
	output logic rx_gap_drop_out
);
	import pmsc_pkg::*;

	// ------------------------------------------------------------
	// Declarations.
	// ------------------------------------------------------------
	logic [CNT_W-1:0] cnt [CNT_NUM];
	logic [CNT_NUM-1:0] inc;
	logic [5:0] rx_min_gap_threshold;
	logic [15:0] rx_max_length_limit;
	logic [15:0] rx_min_length_limit;
	pmsc_class_type rx_class;
	pmsc_class_type tx_class;
	logic gap_err;
	logic len_err;
	logic full_drop;
	logic [15:0] gap_limit;
	logic [7:0] word_idx;
	logic aligned;
	logic req;
	logic accept;

	// Destination class: all ones is broadcast, group bit set is multicast.
	function automatic pmsc_class_type classify(input logic [47:0] addr);
		pmsc_class_type cls;
		cls = CLS_UNICAST;
		if (&addr)
			cls = CLS_BROADCAST;
		else if (addr[40])
			cls = CLS_MULTICAST;
		return cls;
	endfunction : classify

	// ------------------------------------------------------------
	// Frame event decode.
	// ------------------------------------------------------------

	// Classify both directions with the same decoder.
	always_comb
	begin
		rx_class = classify(rx_event_in.dest_addr);
		tx_class = classify(tx_event_in.dest_addr);
	end

	// Gap limit is the threshold in octets expressed in bit times.
	assign gap_limit = 16'(rx_min_gap_threshold) << GAP_UNIT_SHIFT;
	// A gap equal to the limit is still an error, only a larger one passes.
	assign gap_err = rx_event_in.gap_bits <= gap_limit;
	// Length outside the programmed window in either direction.
	assign len_err = (rx_event_in.length > rx_max_length_limit) ||
		(rx_event_in.length < rx_min_length_limit);

	// A drop counts only when every chosen destination FIFO is full, so a
	// flooded frame that still reaches one FIFO is not counted.
	assign full_drop = (rx_event_in.to_host || rx_event_in.to_port) &&
		(!rx_event_in.to_host || rx_event_in.host_fifo_full) &&
		(!rx_event_in.to_port || rx_event_in.port_fifo_full);

	// Increment requests, one bit per counter slot.
	always_comb
	begin
		inc = '0;
		inc[SLOT_RX_TOTAL] = rx_event_in.valid;
		inc[SLOT_RX_BCAST] = rx_event_in.valid && rx_class == CLS_BROADCAST;
		inc[SLOT_RX_MCAST] = rx_event_in.valid && rx_class == CLS_MULTICAST;
		inc[SLOT_RX_UCAST] = rx_event_in.valid && rx_class == CLS_UNICAST;
		inc[SLOT_RX_FCS] = rx_event_in.valid && rx_event_in.fcs_err;
		inc[SLOT_RX_ALIGN] = rx_event_in.valid && rx_event_in.align_err;
		inc[SLOT_RX_LENGTH] = rx_event_in.valid && len_err;
		inc[SLOT_RX_PHY] = rx_event_in.valid && rx_event_in.phy_err;
		inc[SLOT_TX_TOTAL] = tx_event_in.valid;
		inc[SLOT_TX_BCAST] = tx_event_in.valid && tx_class == CLS_BROADCAST;
		inc[SLOT_TX_MCAST] = tx_event_in.valid && tx_class == CLS_MULTICAST;
		inc[SLOT_TX_UCAST] = tx_event_in.valid && tx_class == CLS_UNICAST;
		inc[SLOT_DROP_FULL] = rx_event_in.valid && full_drop;
		inc[SLOT_DROP_FILT] = rx_event_in.valid && rx_event_in.filter_reject;
		inc[SLOT_RX_GAP] = rx_event_in.valid && gap_err;
	end

	// ------------------------------------------------------------
	// Counter bank.
	// ------------------------------------------------------------

	// Each counter wraps naturally; software has no write path to them.
	generate
		for (genvar g = 0; g < CNT_NUM; g++)
		begin : gen_cnt
			always_ff @(posedge mclk_in or negedge rst_n_in)
			begin
				if (!rst_n_in)
					cnt[g] <= CNT_RESET;
				else if (inc[g])
					cnt[g] <= cnt[g] + 32'h1;
			end
		end
	endgenerate

	// Gap error event and the matching drop order, one cycle each.
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rx_gap_error_event_out <= 1'b0;
			rx_gap_drop_out <= 1'b0;
		end
		else
		begin
			rx_gap_error_event_out <= rx_event_in.valid && gap_err;
			rx_gap_drop_out <= rx_event_in.valid && gap_err;
		end
	end

	// ------------------------------------------------------------
	// Avalon-MM slave.
	// ------------------------------------------------------------

	assign word_idx = avs_address_in[9:2];
	assign aligned = avs_address_in[1:0] == 2'h0;
	assign req = avs_read_in || avs_write_in;
	// The cycle where waitrequest is low is the one that completes a request.
	assign accept = req && !avs_waitrequest_out;

	// Waitrequest drops for one cycle after each request is seen.
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			avs_waitrequest_out <= 1'b1;
		else if (req && avs_waitrequest_out)
			avs_waitrequest_out <= 1'b0;
		else
			avs_waitrequest_out <= 1'b1;
	end

	// Read data is registered in the wait cycle so it stands at acceptance.
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			avs_readdata_out <= 32'h0;
		else if (avs_read_in && avs_waitrequest_out)
		begin
			avs_readdata_out <= 32'h0;
			if (aligned && word_idx >= IDX_RX_FRAME_TOTAL &&
				word_idx <= IDX_RX_GAP_ERROR_FRAMES)
				avs_readdata_out <= cnt[4'(word_idx - IDX_RX_FRAME_TOTAL)];
			else if (aligned && word_idx == IDX_RX_MIN_GAP_THRESHOLD)
				avs_readdata_out <= {26'h0, rx_min_gap_threshold};
			else if (aligned && word_idx == IDX_RX_MAX_LENGTH_LIMIT)
				avs_readdata_out <= {16'h0, rx_max_length_limit};
			else if (aligned && word_idx == IDX_RX_MIN_LENGTH_LIMIT)
				avs_readdata_out <= {16'h0, rx_min_length_limit};
		end
	end

	// Limit registers; writes to counters or unmapped words are dropped.
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rx_min_gap_threshold <= GAP_THRESHOLD_RESET;
			rx_max_length_limit <= MAX_LENGTH_RESET;
			rx_min_length_limit <= MIN_LENGTH_RESET;
		end
		else if (accept && avs_write_in && aligned)
		begin
			if (word_idx == IDX_RX_MIN_GAP_THRESHOLD && avs_byteenable_in[0])
				rx_min_gap_threshold <= avs_writedata_in[5:0];
			if (word_idx == IDX_RX_MAX_LENGTH_LIMIT)
			begin
				if (avs_byteenable_in[0])
					rx_max_length_limit[7:0] <= avs_writedata_in[7:0];
				if (avs_byteenable_in[1])
					rx_max_length_limit[15:8] <= avs_writedata_in[15:8];
			end
			if (word_idx == IDX_RX_MIN_LENGTH_LIMIT)
			begin
				if (avs_byteenable_in[0])
					rx_min_length_limit[7:0] <= avs_writedata_in[7:0];
				if (avs_byteenable_in[1])
					rx_min_length_limit[15:8] <= avs_writedata_in[15:8];
			end
		end
	end

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);

	// A request is answered exactly one cycle after it is first seen.
	sequence s_req_seen;
		req && avs_waitrequest_out;
	endsequence
	sequence s_answer;
		!avs_waitrequest_out;
	endsequence

	// Receive and transmit frame event sequences.
	sequence s_rx_frame;
		rx_event_in.valid;
	endsequence
	sequence s_tx_frame;
		tx_event_in.valid;
	endsequence

	chk_bus_answer_delay: assert property (s_req_seen |=> s_answer)
		else $error("waitrequest did not drop one cycle after the request");
	chk_rx_total_step: assert property (s_rx_frame |=>
		cnt[SLOT_RX_TOTAL] == $past(cnt[SLOT_RX_TOTAL]) + 32'h1)
		else $error("receive total did not advance on a frame");
	chk_rx_bcast_step: assert property (s_rx_frame ##0 (&rx_event_in.dest_addr) |=>
		cnt[SLOT_RX_BCAST] == $past(cnt[SLOT_RX_BCAST]) + 32'h1)
		else $error("receive broadcast count missed a broadcast frame");
	chk_rx_mcast_step: assert property (s_rx_frame ##0
		(rx_event_in.dest_addr[40] && !(&rx_event_in.dest_addr)) |=>
		cnt[SLOT_RX_MCAST] == $past(cnt[SLOT_RX_MCAST]) + 32'h1)
		else $error("receive multicast count missed a multicast frame");
	chk_rx_ucast_step: assert property (s_rx_frame ##0 !rx_event_in.dest_addr[40] |=>
		cnt[SLOT_RX_UCAST] == $past(cnt[SLOT_RX_UCAST]) + 32'h1)
		else $error("receive unicast count missed a unicast frame");
	chk_fcs_count: assert property (s_rx_frame ##0 rx_event_in.fcs_err |=>
		cnt[SLOT_RX_FCS] == $past(cnt[SLOT_RX_FCS]) + 32'h1)
		else $error("FCS error count did not move");
	chk_align_count: assert property (s_rx_frame ##0 rx_event_in.align_err |=>
		cnt[SLOT_RX_ALIGN] == $past(cnt[SLOT_RX_ALIGN]) + 32'h1)
		else $error("alignment error count did not move");
	chk_length_window: assert property (s_rx_frame ##0
		(rx_event_in.length > rx_max_length_limit) |=>
		cnt[SLOT_RX_LENGTH] == $past(cnt[SLOT_RX_LENGTH]) + 32'h1)
		else $error("overlong frame not counted as length error");
	chk_phy_count: assert property (!rx_event_in.valid |=>
		cnt[SLOT_RX_PHY] == $past(cnt[SLOT_RX_PHY]))
		else $error("PHY error count moved without a frame");
	chk_tx_total_step: assert property (s_tx_frame |=>
		cnt[SLOT_TX_TOTAL] == $past(cnt[SLOT_TX_TOTAL]) + 32'h1)
		else $error("transmit total did not advance on a frame");
	chk_tx_class_onehot: assert property (s_tx_frame |->
		$onehot(inc[SLOT_TX_UCAST:SLOT_TX_BCAST]))
		else $error("transmit frame not placed in exactly one class");
	chk_flood_one_full: assert property (s_rx_frame ##0
		(rx_event_in.to_host && rx_event_in.to_port &&
		(rx_event_in.host_fifo_full != rx_event_in.port_fifo_full)) |=>
		$stable(cnt[SLOT_DROP_FULL]))
		else $error("flooded frame with one free FIFO counted as full drop");
	chk_flood_both_full: assert property (s_rx_frame ##0
		(rx_event_in.to_host && rx_event_in.host_fifo_full &&
		(!rx_event_in.to_port || rx_event_in.port_fifo_full)) |=>
		cnt[SLOT_DROP_FULL] == $past(cnt[SLOT_DROP_FULL]) + 32'h1)
		else $error("full drop not counted");
	chk_filter_count: assert property (s_rx_frame ##0 rx_event_in.filter_reject |=>
		cnt[SLOT_DROP_FILT] == $past(cnt[SLOT_DROP_FILT]) + 32'h1)
		else $error("filter drop not counted");
	chk_gap_event: assert property (s_rx_frame ##0
		(rx_event_in.gap_bits <= {7'h0, rx_min_gap_threshold, 3'h0}) |=>
		rx_gap_error_event_out && rx_gap_drop_out &&
		cnt[SLOT_RX_GAP] == $past(cnt[SLOT_RX_GAP]) + 32'h1)
		else $error("short gap did not raise the gap error event");
	chk_gap_quiet: assert property (!rx_event_in.valid |=> !rx_gap_error_event_out)
		else $error("gap error event without a frame");
	chk_rx_class_onehot: assert property (s_rx_frame |->
		$onehot(inc[SLOT_RX_UCAST:SLOT_RX_BCAST]))
		else $error("receive frame not placed in exactly one class");
	chk_read_no_effect: assert property ((accept && avs_read_in && !rx_event_in.valid) |=>
		cnt[SLOT_RX_TOTAL] == $past(cnt[SLOT_RX_TOTAL]))
		else $error("reading changed a counter");
	chk_write_ignored: assert property ((accept && avs_write_in && !tx_event_in.valid) |=>
		$stable(cnt[SLOT_TX_TOTAL]))
		else $error("write reached a read-only counter");

	// Error and transmit class counters move on their own events; length, drop and gap counters hold otherwise.
	chk_phy_step: assert property (s_rx_frame ##0 rx_event_in.phy_err |=>
		cnt[SLOT_RX_PHY] == $past(cnt[SLOT_RX_PHY]) + 32'h1)
		else $error("PHY error count missed a frame");
	chk_length_short: assert property (s_rx_frame ##0
		(rx_event_in.length < rx_min_length_limit) |=>
		cnt[SLOT_RX_LENGTH] == $past(cnt[SLOT_RX_LENGTH]) + 32'h1)
		else $error("short frame not counted as length error");
	chk_length_fits: assert property (s_rx_frame ##0
		(rx_event_in.length <= rx_max_length_limit &&
		rx_event_in.length >= rx_min_length_limit) |=> $stable(cnt[SLOT_RX_LENGTH]))
		else $error("frame inside the length window counted as length error");
	chk_tx_bcast_step: assert property (s_tx_frame ##0 (&tx_event_in.dest_addr) |=>
		cnt[SLOT_TX_BCAST] == $past(cnt[SLOT_TX_BCAST]) + 32'h1)
		else $error("transmit broadcast count missed a broadcast frame");
	chk_tx_mcast_step: assert property (s_tx_frame ##0
		(tx_event_in.dest_addr[40] && !(&tx_event_in.dest_addr)) |=>
		cnt[SLOT_TX_MCAST] == $past(cnt[SLOT_TX_MCAST]) + 32'h1)
		else $error("transmit multicast count missed a multicast frame");
	chk_tx_ucast_step: assert property (s_tx_frame ##0 !tx_event_in.dest_addr[40] |=>
		cnt[SLOT_TX_UCAST] == $past(cnt[SLOT_TX_UCAST]) + 32'h1)
		else $error("transmit unicast count missed a unicast frame");
	chk_drop_no_dest: assert property (s_rx_frame ##0
		!(rx_event_in.to_host || rx_event_in.to_port) |=> $stable(cnt[SLOT_DROP_FULL]))
		else $error("frame without a destination counted as full drop");
	chk_gap_pass: assert property (s_rx_frame ##0
		(rx_event_in.gap_bits > {7'h0, rx_min_gap_threshold, 3'h0}) |=>
		!rx_gap_drop_out && $stable(cnt[SLOT_RX_GAP]))
		else $error("long enough gap was treated as a gap error");
	chk_filter_quiet: assert property (!(rx_event_in.valid && rx_event_in.filter_reject) |=>
		$stable(cnt[SLOT_DROP_FILT]))
		else $error("filter drop count moved without a rejected frame");

	// An idle bus keeps waitrequest high; an accepted write lands in its register.
	sequence s_idle;
		!req;
	endsequence
	sequence s_len_write;
		accept && avs_write_in && aligned && word_idx == IDX_RX_MAX_LENGTH_LIMIT &&
			avs_byteenable_in[1:0] == 2'h3;
	endsequence
	chk_idle_wait: assert property (s_idle |=> avs_waitrequest_out)
		else $error("waitrequest low without a request");
	chk_limit_write: assert property (s_len_write |=>
		rx_max_length_limit == $past(avs_writedata_in[15:0]))
		else $error("accepted write did not reach the maximum length limit");
	chk_read_hold: assert property (!(avs_read_in && avs_waitrequest_out) |=>
		$stable(avs_readdata_out))
		else $error("read data changed outside a read");

	// Each counter moves by one exactly when asked and otherwise holds.
	generate
		for (genvar a = 0; a < CNT_NUM; a++)
		begin : gen_cnt_chk
			chk_cnt_step: assert property (inc[a] |=>
				cnt[a] == $past(cnt[a]) + 32'h1)
				else $error("counter did not advance by one");
			chk_cnt_hold: assert property (!inc[a] |=> $stable(cnt[a]))
				else $error("counter moved without an event");
		end
	endgenerate

endmodule : pmsc_counters

// ==== test/test_pmsc_counters.sv ====
// Self-checking bench for the port MAC statistics counter bank.
`timescale 1ns/1ps
module test_pmsc_counters;
	import pmsc_pkg::*;

	// ------------------------------------------------------------
	// Signals, expected state and tallies.
	// ------------------------------------------------------------
	localparam logic [47:0] BC = 48'hffff_ffff_ffff;
	localparam logic [47:0] MC = 48'h0100_5e00_0001;
	localparam logic [47:0] UC = 48'h0200_0000_0001;
	logic mclk_in;
	logic rst_n_in;
	logic [9:0] avs_address_in;
	logic avs_read_in;
	logic avs_write_in;
	logic [3:0] avs_byteenable_in;
	logic [31:0] avs_writedata_in;
	logic [31:0] avs_readdata_out;
	logic avs_waitrequest_out;
	pmsc_rx_event_type rx_event_in;
	pmsc_tx_event_type tx_event_in;
	logic rx_gap_error_event_out;
	logic rx_gap_drop_out;
	logic [31:0] exp_cnt [CNT_NUM];
	logic [5:0] exp_thr;
	logic [15:0] exp_max;
	logic [15:0] exp_min;
	logic [31:0] rd;
	logic [7:0] flag_tab [13] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01,
		8'h0a, 8'h05, 8'h0e, 8'h0d, 8'h0f};
	logic [5:0] thr_tab [3] = '{6'h0a, 6'h00, 6'h3f};
	logic [15:0] lens [4];
	int bad_count;
	int checks_done;

	// Design under test.
	pmsc_counters pmsc_counters_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
		.avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .rx_event_in(rx_event_in),
		.tx_event_in(tx_event_in), .rx_gap_error_event_out(rx_gap_error_event_out),
		.rx_gap_drop_out(rx_gap_drop_out));

	// Clock at 40 MHz.
	always #12.5 mclk_in = ~mclk_in;

	// ------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------
	function automatic logic [47:0] dest(input int i);
		return (i % 3 == 0) ? BC : ((i % 3 == 1) ? MC : UC);
	endfunction : dest

	function automatic pmsc_rx_event_type rxf(input logic [47:0] d, input logic [15:0] len,
		input logic [15:0] gap, input logic [7:0] fl);
		return {1'b1, d, len, gap, fl};
	endfunction : rxf

	// Prints the counts and the verdict, then ends the run.
	task complete_run;
		$display("comparisons %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	task check(input logic [31:0] seen, input logic [31:0] want, input string what);
		checks_done++;
		if (seen !== want)
		begin
			bad_count++;
			$display("unexpected at %0t: %s gave %h, wanted %h", $time, what, seen, want);
		end
	endtask : check

	// One Avalon access; the request is held until waitrequest is sampled low.
	task bus(input logic wr, input logic [9:0] addr, input logic [31:0] wdata,
		output logic [31:0] data);
		int n;
		@(posedge mclk_in);
		avs_address_in <= addr;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		avs_writedata_in <= wdata;
		n = 0;
		do
		begin
			@(posedge mclk_in);
			n++;
		end
		while (avs_waitrequest_out !== 1'b0 && n < 20);
		if (avs_waitrequest_out !== 1'b0)
		begin
			bad_count++;
			$display("unexpected at %0t: bus access never answered", $time);
			complete_run();
		end
		data = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask : bus

	task reset_exp;
		foreach (exp_cnt[i])
			exp_cnt[i] = CNT_RESET;
		exp_thr = GAP_THRESHOLD_RESET;
		exp_max = MAX_LENGTH_RESET;
		exp_min = MIN_LENGTH_RESET;
	endtask : reset_exp

	task check_all(input string what);
		for (int i = 0; i < CNT_NUM; i++)
		begin
			bus(1'b0, 10'h280 + 10'(4 * i), 32'h0, rd);
			check(rd, exp_cnt[i], what);
		end
		bus(1'b0, 10'h2d4, 32'h0, rd);
		check(rd, {26'h0, exp_thr}, "gap threshold");
		bus(1'b0, 10'h2d8, 32'h0, rd);
		check(rd, {16'h0, exp_max}, "max length");
		bus(1'b0, 10'h2dc, 32'h0, rd);
		check(rd, {16'h0, exp_min}, "min length");
		$display("test %s finished", what);
	endtask : check_all

	// Expected counter effects of one rx and one tx event.
	task model(input pmsc_rx_event_type rx, input pmsc_tx_event_type tx, input logic gap_bad);
		if (rx.valid)
		begin
			exp_cnt[SLOT_RX_TOTAL]++;
			if (&rx.dest_addr)
				exp_cnt[SLOT_RX_BCAST]++;
			else if (rx.dest_addr[40])
				exp_cnt[SLOT_RX_MCAST]++;
			else
				exp_cnt[SLOT_RX_UCAST]++;
			exp_cnt[SLOT_RX_FCS] += 32'(rx.fcs_err);
			exp_cnt[SLOT_RX_ALIGN] += 32'(rx.align_err);
			exp_cnt[SLOT_RX_LENGTH] += 32'(rx.length > exp_max || rx.length < exp_min);
			exp_cnt[SLOT_RX_PHY] += 32'(rx.phy_err);
			exp_cnt[SLOT_DROP_FULL] += 32'((rx.to_host || rx.to_port)
				&& (!rx.to_host || rx.host_fifo_full) && (!rx.to_port || rx.port_fifo_full));
			exp_cnt[SLOT_DROP_FILT] += 32'(rx.filter_reject);
			exp_cnt[SLOT_RX_GAP] += 32'(gap_bad);
		end
		if (tx.valid)
		begin
			exp_cnt[SLOT_TX_TOTAL]++;
			if (&tx.dest_addr)
				exp_cnt[SLOT_TX_BCAST]++;
			else if (tx.dest_addr[40])
				exp_cnt[SLOT_TX_MCAST]++;
			else
				exp_cnt[SLOT_TX_UCAST]++;
		end
	endtask : model

	// Drives one cycle of events and checks the gap pulses that follow.
	task send(input pmsc_rx_event_type rx, input pmsc_tx_event_type tx);
		logic gap_bad;
		gap_bad = rx.valid && (rx.gap_bits <= {7'h0, exp_thr, 3'h0});
		@(posedge mclk_in);
		rx_event_in <= rx;
		tx_event_in <= tx;
		@(posedge mclk_in);
		rx_event_in <= '0;
		tx_event_in <= '0;
		model(rx, tx, gap_bad);
		@(posedge mclk_in);
		check({30'h0, rx_gap_error_event_out, rx_gap_drop_out}, {30'h0, {2{gap_bad}}}, "gap");
		@(posedge mclk_in);
		check({30'h0, rx_gap_error_event_out, rx_gap_drop_out}, 32'h0, "gap end");
	endtask : send

	// ------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------
	initial
	begin
		mclk_in = 1'b0;
		rst_n_in = 1'b0;
		avs_address_in = 10'h0;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_byteenable_in = 4'hf;
		avs_writedata_in = 32'h0;
		rx_event_in = '0;
		tx_event_in = '0;
		bad_count = 0;
		checks_done = 0;
		reset_exp();
		repeat (6) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		check_all("reset values");
		for (int i = 0; i < 13; i++)
			send(rxf(dest(i), 16'h100, 16'h100, flag_tab[i]), {1'b1, dest(i + 1)});
		check_all("classes and flags");
		@(posedge mclk_in);
		rx_event_in <= rxf(UC, 16'h100, 16'h100, 8'h80);
		@(posedge mclk_in);
		rx_event_in <= rxf(MC, 16'h100, 16'h100, 8'h40);
		@(posedge mclk_in);
		rx_event_in <= '0;
		model(rxf(UC, 16'h100, 16'h100, 8'h80), '0, 1'b0);
		model(rxf(MC, 16'h100, 16'h100, 8'h40), '0, 1'b0);
		check_all("back to back");
		foreach (thr_tab[t])
		begin
			bus(1'b1, 10'h2d4, {26'h0, thr_tab[t]}, rd);
			exp_thr = thr_tab[t];
			send(rxf(BC, 16'h100, {7'h0, exp_thr, 3'h0}, 8'h08), '0);
			send(rxf(BC, 16'h100, {7'h0, exp_thr, 3'h0} + 16'h1, 8'h08), '0);
		end
		check_all("gap threshold");
		for (int s = 0; s < 2; s++)
		begin
			lens = '{exp_max + 16'h1, exp_max, exp_min, exp_min - 16'h1};
			foreach (lens[k])
				send(rxf(UC, lens[k], 16'h200, 8'h08), '0);
			bus(1'b1, 10'h2d8, 32'h100, rd);
			bus(1'b1, 10'h2dc, 32'h80, rd);
			exp_max = 16'h100;
			exp_min = 16'h80;
		end
		check_all("length limits");
		avs_byteenable_in <= 4'h1;
		bus(1'b1, 10'h2d8, 32'h0000_ab77, rd);
		avs_byteenable_in <= 4'hf;
		exp_max = 16'h0177;
		bus(1'b1, 10'h280, 32'hffff_ffff, rd);
		bus(1'b1, 10'h2b8, 32'h1234_5678, rd);
		bus(1'b1, 10'h300, 32'hffff_ffff, rd);
		bus(1'b0, 10'h300, 32'h0, rd);
		check(rd, 32'h0, "unmapped read");
		bus(1'b0, 10'h281, 32'h0, rd);
		check(rd, 32'h0, "unaligned read");
		check_all("read only");
		check_all("repeat read");
		@(posedge mclk_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		reset_exp();
		check_all("second reset");
		complete_run();
	end

endmodule : test_pmsc_counters
